// ### hw/timer_gated_pwm_generator.sv
// What this block does
// - Gate code 00001 holds timer while gate high
// - Gate code 00010 holds timer while gate low
// - Gate hold stretches period and high time
// - Per-channel timebase select, defaults to period timer
// - Standard PWM runs on 8-bit period timer
// - Period is (match+1) times four times prescale
// - Pin set at period start unless duty zero
// - Duty copied into 10-bit buffer at start
// - Postscaler never changes PWM frequency
// - 10-bit duty, alignment bit picks justification
// - Duty writes take effect after next match
// - On bit synchronized before the timer acts
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module timer_gated_pwm_generator (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic external_gate_signal,
  output logic capture_pwm_channel_out,
  output logic capture_pwm_channel_oe,
  output logic irq
);
  timer_link_if lnk ();

  // Software registers
  logic [15:0] ctrl_ff;
  pwm_pkg::count_type period_match_value_ff;
  logic [15:0] duty_cycle_value_ff;
  logic [1:0] channel_timebase_select_ff;
  logic [1:0] status_ff;
  logic [1:0] nxt_status;
  logic [1:0] ien_ff;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  // Synchronizers
  logic on_s1_ff;
  logic on_s2_ff;
  logic gate_s1_ff;
  logic gate_s2_ff;

  // PWM state
  logic [9:0] duty_buf_ff;
  logic pwm_ff;
  logic nxt_pwm;
  logic oe_ff;
  logic irq_ff;
  logic [3:0] post_cnt_ff;
  logic [3:0] nxt_post_cnt;

  // Address decode
  wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
  wire wr_period = reg_wr && (reg_addr == `OFS_PERIOD);
  wire wr_duty = reg_wr && (reg_addr == `OFS_DUTY);
  wire wr_tsel = reg_wr && (reg_addr == `OFS_TSEL);
  wire wr_ien = reg_wr && (reg_addr == `OFS_IEN);
  wire wr_iclr = reg_wr && (reg_addr == `OFS_ICLR);

  // Control fields
  wire on_bit = ctrl_ff[`CTRL_ON];
  wire [3:0] post_set = ctrl_ff[`CTRL_POST_HI:`CTRL_POST_LO];
  wire align_left = ctrl_ff[`CTRL_ALIGN];
  wire pin_direction_control = ctrl_ff[`CTRL_DIR];

  // Channel uses the period timer only when selected
  wire pwm_run = (channel_timebase_select_ff == `TSEL_PERIOD);

  // Duty value taken from either justification
  wire [9:0] duty_sel = align_left ? duty_cycle_value_ff[15:6]
                                   : duty_cycle_value_ff[9:0];

  // Extended count and duty compare
  wire [9:0] ext_count = {lnk.period_timer_count, lnk.frac};
  wire period_start = lnk.period_evt && pwm_run;
  wire duty_hit = pwm_run && !lnk.period_evt && pwm_ff && (ext_count == duty_buf_ff);

  // Postscaler only paces the period flag
  wire post_hit = lnk.period_evt && (post_cnt_ff >= post_set);
  assign nxt_post_cnt = !lnk.period_evt ? post_cnt_ff :
                        (post_hit ? 4'h0 : post_cnt_ff + 4'h1);

  // Sticky flags where a new event wins over a clear
  wire [1:0] evt_vec = {duty_hit, post_hit};
  wire [1:0] clr_vec = wr_iclr ? reg_wdata[1:0] : 2'h0;
  assign nxt_status = (status_ff & ~clr_vec) | evt_vec;

  // Pin level for the next cycle
  assign nxt_pwm = !pwm_run ? 1'b0 :
                   period_start ? (duty_sel != 10'h000) :
                   duty_hit ? 1'b0 : pwm_ff;

  // Read mux
  assign nxt_rdata = !reg_rd ? 16'h0000 :
                     (reg_addr == `OFS_CTRL) ? ctrl_ff :
                     (reg_addr == `OFS_PERIOD) ? {8'h00, period_match_value_ff} :
                     (reg_addr == `OFS_DUTY) ? duty_cycle_value_ff :
                     (reg_addr == `OFS_TSEL) ? {14'h0000, channel_timebase_select_ff} :
                     (reg_addr == `OFS_STAT) ? {14'h0000, status_ff} :
                     (reg_addr == `OFS_IEN) ? {14'h0000, ien_ff} :
                     (reg_addr == `OFS_COUNT) ? {5'h00, pwm_ff, ext_count} :
                     16'h0000;

  // Timer link
  assign lnk.run = on_s2_ff;
  assign lnk.gate_level = gate_s2_ff;
  assign lnk.gate_mode = ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign lnk.prescale = pwm_pkg::prescale_type'(ctrl_ff[`CTRL_PRE_HI:`CTRL_PRE_LO]);
  assign lnk.period_match_value = period_match_value_ff;

  period_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .lnk(lnk)
  );

  // Register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= `CTRL_RST;
      period_match_value_ff <= `PERIOD_RST;
      duty_cycle_value_ff <= `DUTY_RST;
      channel_timebase_select_ff <= `TSEL_RST;
      ien_ff <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata;
      end
      if (wr_period) begin
        period_match_value_ff <= reg_wdata[7:0];
      end
      if (wr_duty) begin
        duty_cycle_value_ff <= reg_wdata;
      end
      if (wr_tsel) begin
        channel_timebase_select_ff <= reg_wdata[`TSEL_HI:`TSEL_LO];
      end
      if (wr_ien) begin
        ien_ff <= reg_wdata[1:0];
      end
    end
  end

  // On bit and gate pin cross into the timer logic
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_s1_ff <= 1'b0;
      on_s2_ff <= 1'b0;
      gate_s1_ff <= 1'b0;
      gate_s2_ff <= 1'b0;
    end else begin
      on_s1_ff <= on_bit;
      on_s2_ff <= on_s1_ff;
      gate_s1_ff <= external_gate_signal;
      gate_s2_ff <= gate_s1_ff;
    end
  end

  // Duty buffer loads only at the start of a period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty_buf_ff <= 10'h000;
    end else if (period_start) begin
      duty_buf_ff <= duty_sel;
    end
  end

  // Pin, driver enable, flags, interrupt and read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_ff <= 1'b0;
      oe_ff <= 1'b0;
      status_ff <= 2'h0;
      post_cnt_ff <= 4'h0;
      irq_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      pwm_ff <= nxt_pwm;
      oe_ff <= !pin_direction_control;
      status_ff <= nxt_status;
      post_cnt_ff <= nxt_post_cnt;
      irq_ff <= |(nxt_status & ien_ff);
      rdata_ff <= nxt_rdata;
    end
  end

  assign capture_pwm_channel_out = pwm_ff;
  assign capture_pwm_channel_oe = oe_ff;
  assign irq = irq_ff;
  assign reg_rdata = rdata_ff;
endmodule

// ### hw/pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH

// Register offsets
`define OFS_CTRL 4'h0
`define OFS_PERIOD 4'h1
`define OFS_DUTY 4'h2
`define OFS_TSEL 4'h3
`define OFS_STAT 4'h4
`define OFS_IEN 4'h5
`define OFS_ICLR 4'h6
`define OFS_COUNT 4'h7

// Control register fields
`define CTRL_ON 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 5
`define CTRL_PRE_LO 6
`define CTRL_PRE_HI 7
`define CTRL_POST_LO 8
`define CTRL_POST_HI 11
`define CTRL_ALIGN 12
`define CTRL_DIR 13
`define CTRL_RST 16'h2000

// Timebase select field
`define TSEL_LO 0
`define TSEL_HI 1
`define TSEL_RST 2'h1
`define TSEL_PERIOD 2'h1

// Status and interrupt bits
`define ST_PERIOD 0
`define ST_TRAIL 1

// Other reset values
`define PERIOD_RST 8'hff
`define DUTY_RST 16'h0000

// Gate modes
`define GATE_SW 5'h00
`define GATE_HOLD_HI 5'h01
`define GATE_HOLD_LO 5'h02

// Oscillator periods per timer increment before prescale
`define FOSC_DIV 4

// Last prescaler step for each prescale choice
`define SUB_LAST_1 8'h03
`define SUB_LAST_4 8'h0f
`define SUB_LAST_16 8'h3f
`define SUB_LAST_64 8'hff

`endif

// ### hw/pwm_pkg.sv
package pwm_pkg;
  typedef enum logic [1:0] {presc_1, presc_4, presc_16, presc_64} prescale_type;
  typedef logic [7:0] count_type;
  typedef logic [4:0] gate_mode_type;
endpackage

// ### hw/timer_link_if.sv
`timescale 1ns/1ps
interface timer_link_if;
  logic run;
  logic gate_level;
  pwm_pkg::gate_mode_type gate_mode;
  pwm_pkg::prescale_type prescale;
  pwm_pkg::count_type period_match_value;
  pwm_pkg::count_type period_timer_count;
  logic [1:0] frac;
  logic period_evt;

  modport timer (
    input run,
    input gate_level,
    input gate_mode,
    input prescale,
    input period_match_value,
    output period_timer_count,
    output frac,
    output period_evt
  );
  modport ctrl (
    output run,
    output gate_level,
    output gate_mode,
    output prescale,
    output period_match_value,
    input period_timer_count,
    input frac,
    input period_evt
  );
endinterface

// ### hw/period_timer.sv
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module period_timer (
  input wire logic clk,
  input wire logic rst_n,
  timer_link_if.timer lnk
);
  logic [7:0] sub_ff;
  logic [7:0] nxt_sub;
  pwm_pkg::count_type count_ff;
  pwm_pkg::count_type nxt_count;
  logic evt_ff;
  logic [7:0] sub_last;
  wire gated_hi = (lnk.gate_mode == `GATE_HOLD_HI) && lnk.gate_level;
  wire gated_lo = (lnk.gate_mode == `GATE_HOLD_LO) && !lnk.gate_level;
  wire hold = !lnk.run || gated_hi || gated_lo;
  // Prescaler wraps at once if a smaller prescale is chosen mid-count
  wire step = !hold && (sub_ff >= sub_last);
  wire match = step && (count_ff == lnk.period_match_value);

  // Prescale of four oscillator periods times 1, 4, 16 or 64
  assign sub_last = (lnk.prescale == pwm_pkg::presc_1) ? `SUB_LAST_1 :
                    (lnk.prescale == pwm_pkg::presc_4) ? `SUB_LAST_4 :
                    (lnk.prescale == pwm_pkg::presc_16) ? `SUB_LAST_16 :
                    `SUB_LAST_64;
  assign nxt_sub = hold ? sub_ff : (step ? 8'h00 : sub_ff + 8'h01);
  assign nxt_count = match ? 8'h00 : (step ? count_ff + 8'h01 : count_ff);

  // Two top prescaler bits extend the count for the duty compare
  assign lnk.frac = (lnk.prescale == pwm_pkg::presc_1) ? sub_ff[1:0] :
                    (lnk.prescale == pwm_pkg::presc_4) ? sub_ff[3:2] :
                    (lnk.prescale == pwm_pkg::presc_16) ? sub_ff[5:4] :
                    sub_ff[7:6];
  assign lnk.period_timer_count = count_ff;
  assign lnk.period_evt = evt_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sub_ff <= 8'h00;
      count_ff <= 8'h00;
      evt_ff <= 1'b0;
    end else begin
      sub_ff <= nxt_sub;
      count_ff <= nxt_count;
      evt_ff <= match;
    end
  end
endmodule

// ### test/pwm_gen_props.sv
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module pwm_gen_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic external_gate_signal,
  input wire logic capture_pwm_channel_out,
  input wire logic capture_pwm_channel_oe,
  input wire logic irq
);
  logic [4:0] mode_ff;
  wire ctl_wr = reg_wr && reg_addr == `OFS_CTRL;
  wire hold_hi = mode_ff == `GATE_HOLD_HI && external_gate_signal;
  wire hold_lo = mode_ff == `GATE_HOLD_LO && !external_gate_signal;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= `GATE_SW;
    end else if (ctl_wr) begin
      mode_ff <= reg_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_gate_hi_hold: assert property (hold_hi [*6] |=> $stable(capture_pwm_channel_out))
    else $error("pin moved in hold");
  chk_gate_lo_hold: assert property (hold_lo [*6] |=> $stable(capture_pwm_channel_out))
    else $error("pin moved in hold");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("rdata not zero");
  chk_clear_reads_zero: assert property (reg_rd && reg_addr == `OFS_ICLR |=> reg_rdata == 16'h0000)
    else $error("clear reg read");
  chk_oe_follows_dir: assert property (ctl_wr |-> ##2 capture_pwm_channel_oe == !$past(reg_wdata[`CTRL_DIR], 2))
    else $error("oe not dir");
  chk_oe_quiet: assert property (!reg_wr && !$past(reg_wr) |=> $stable(capture_pwm_channel_oe))
    else $error("oe moved");
  chk_irq_masked: assert property (reg_wr && reg_addr == `OFS_IEN && reg_wdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq not masked");
  chk_tsel_pin_low: assert property (reg_wr && reg_addr == `OFS_TSEL &&
    reg_wdata[1:0] != `TSEL_PERIOD |-> ##3 !capture_pwm_channel_out)
    else $error("pin not low");
  cover property (ctl_wr ##2 capture_pwm_channel_oe);
  cover property ($rose(irq));
  cover property (hold_hi [*6]);
endmodule
bind timer_gated_pwm_generator pwm_gen_props pwm_gen_props_i (.clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_gate_signal,
  .capture_pwm_channel_out, .capture_pwm_channel_oe, .irq);

// ### test/pwm_load.sv
`timescale 1ns/1ps
module pwm_load (
  input wire logic clk,
  input wire logic clr,
  input wire logic pin,
  input wire logic oe,
  output int high_cnt,
  output int rise_cnt
);
  logic seen_ff;
  wire lvl = pin && oe;
  // Undriven pin reads low through the load
  always @(posedge clk) begin
    seen_ff <= lvl;
    if (clr) begin
      high_cnt <= 0;
      rise_cnt <= 0;
    end else begin
      high_cnt <= high_cnt + int'(lvl);
      rise_cnt <= rise_cnt + int'(lvl && !seen_ff);
    end
  end
endmodule

// ### test/timer_gated_pwm_generator_tb.sv
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module timer_gated_pwm_generator_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gate = 1'b0;
  logic clr = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] last;
  logic [15:0] c0;
  logic pin;
  logic oe;
  logic irq;
  int high_cnt;
  int rise_cnt;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  timer_gated_pwm_generator timer_gated_pwm_generator_i (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_gate_signal(gate),
    .capture_pwm_channel_out(pin), .capture_pwm_channel_oe(oe), .irq);
  pwm_load pwm_load_i (.clk, .clr, .pin, .oe, .high_cnt, .rise_cnt);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic get(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    last = reg_rdata;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    get(a);
    chk(last, e);
  endtask
  task automatic run(input int settle, input int win, input int eh, input int er);
    repeat (settle) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (win) @(posedge clk);
    #1;
    chk(high_cnt, eh);
    chk(rise_cnt, er);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFS_CTRL, `CTRL_RST);
    rd(`OFS_TSEL, 16'h0001);
    rd(4'h8, 16'h0000);
    rd(`OFS_ICLR, 16'h0000);
    wr(`OFS_PERIOD, 16'h0003);
    rd(`OFS_PERIOD, 16'h0003);
    wr(`OFS_DUTY, 16'h0005);
    wr(`OFS_CTRL, 16'h0001);
    run(40, 64, 20, 4);
    wr(`OFS_CTRL, 16'h0f41);
    run(140, 256, 80, 4);
    wr(`OFS_CTRL, 16'h00c1);
    run(1100, 1024, 320, 1);
    wr(`OFS_DUTY, 16'h0140);
    wr(`OFS_CTRL, 16'h1001);
    run(40, 64, 20, 4);
    wr(`OFS_DUTY, 16'h0000);
    run(40, 64, 0, 0);
    wr(`OFS_CTRL, 16'h0001);
    wr(`OFS_DUTY, 16'h03ff);
    run(40, 64, 64, 0);
    wr(`OFS_DUTY, 16'h0005);
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        wr(`OFS_TSEL, k[15:0]);
        run(24, 32, 0, 0);
      end
    end
    wr(`OFS_TSEL, 16'h0001);
    wr(`OFS_CTRL, 16'h0003);
    gate <= 1'b1;
    repeat (8) @(posedge clk);
    get(`OFS_COUNT);
    c0 = last;
    repeat (20) @(posedge clk);
    rd(`OFS_COUNT, c0);
    @(posedge clk);
    gate <= 1'b0;
    repeat (8) @(posedge clk);
    get(`OFS_COUNT);
    chk({15'h0000, last !== c0}, 16'h0001);
    wr(`OFS_CTRL, 16'h0005);
    repeat (6) @(posedge clk);
    get(`OFS_COUNT);
    c0 = last;
    repeat (20) @(posedge clk);
    rd(`OFS_COUNT, c0);
    @(posedge clk);
    gate <= 1'b1;
    repeat (8) @(posedge clk);
    get(`OFS_COUNT);
    chk({15'h0000, last !== c0}, 16'h0001);
    wr(`OFS_CTRL, 16'h0001);
    wr(`OFS_IEN, 16'h0000);
    wr(`OFS_ICLR, 16'h0003);
    repeat (40) @(posedge clk);
    rd(`OFS_STAT, 16'h0003);
    chk(irq, 1'b0);
    wr(`OFS_IEN, 16'h0001);
    for (int i = 0; i < 64 && irq !== 1'b1; i++) @(posedge clk);
    #1;
    chk(irq, 1'b1);
    wr(`OFS_CTRL, 16'h0000);
    repeat (8) @(posedge clk);
    wr(`OFS_ICLR, 16'h0003);
    rd(`OFS_STAT, 16'h0000);
    chk(irq, 1'b0);
    tally_and_finish();
  end
endmodule
